/* File: logic/ipb_bank.sv */
/*
 Interrupt priority bank: one 16-bit priority register behind an
 AXI4-Lite slave, four field stores, and request gating per source.
 Assumes source requests come from logic on aclk; one write and one
 read at most in flight, as AXI4-Lite masters keep.
*/
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module ipb_bank #(
   parameter int ADDR_W = ipb_pkg::IPB_ADDR_W
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address channel
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // Write data channel
   input wire logic [ipb_pkg::IPB_DATA_W-1:0] s_axi_wdata,
   input wire logic [ipb_pkg::IPB_STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // Write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read address channel
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // Read data channel
   output logic [ipb_pkg::IPB_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Source requests, index per ipb_pkg source numbers
   input wire logic [ipb_pkg::IPB_NUM_SRC-1:0] src_request,
   // Gated requests and field values
   output logic [ipb_pkg::IPB_NUM_SRC-1:0] irq_request,
   output logic [ipb_pkg::IPB_FIELD_W-1:0] serial_rx_priority,
   output logic [ipb_pkg::IPB_FIELD_W-1:0] spi_event_priority,
   output logic [ipb_pkg::IPB_FIELD_W-1:0] spi_fault_priority,
   output logic [ipb_pkg::IPB_FIELD_W-1:0] timer_three_priority
);
   import ipb_pkg::*;

   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [IPB_DATA_W-1:0] w_data;
   logic [IPB_STRB_W-1:0] w_strb;
   logic wr_commit;
   logic [IPB_FIELD_W-1:0] prio_val [IPB_NUM_SRC];
   logic [IPB_NUM_SRC-1:0] active_val;
   logic [IPB_REG_W-1:0] reg_view;

   // Word-aligned decode, shared by both directions
   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
      reg_hit = (addr[ADDR_W-1:IPB_WORD_LSB] ==
                 IPB_PRIO_OFFSET[ADDR_W-1:IPB_WORD_LSB]);
   endfunction : reg_hit

   // Protection bits carry no meaning for this register
   assign wr_commit = aw_held && w_held && !s_axi_bvalid;

   // Write address, taken independently of data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         aw_held <= 1'b0;
         s_axi_awready <= 1'b1;
      end
   end

   // Write data, taken independently of address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         w_held <= 1'b0;
         s_axi_wready <= 1'b1;
      end
   end

   // Response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= IPB_RESP_OKAY;
      end else if (wr_commit) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= reg_hit(aw_addr) ? IPB_RESP_OKAY :
                        IPB_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Field stores, one per source
   genvar gi;
   generate
      for (gi = 0; gi < IPB_NUM_SRC; gi++) begin : g_field
         localparam int LSB = IPB_FIELD_LSB[gi];
         ipb_field_if fld_bus ();
         // RULE5 field placement
         // RULE7 only field bits reach stores
         assign fld_bus.wr_en = wr_commit && reg_hit(aw_addr) &&
                                w_strb[LSB / IPB_BYTE_W];
         assign fld_bus.wr_value = w_data[LSB +: IPB_FIELD_W];
         assign prio_val[gi] = fld_bus.value;
         assign active_val[gi] = fld_bus.active;
         ipb_prio_field u_field (
            .aclk (aclk),
            .aresetn (aresetn),
            .fld (fld_bus.store)
         );
      end
   endgenerate

   assign serial_rx_priority = prio_val[IPB_SRC_SERIAL_RX];
   assign spi_event_priority = prio_val[IPB_SRC_SPI_EVENT];
   assign spi_fault_priority = prio_val[IPB_SRC_SPI_FAULT];
   assign timer_three_priority = prio_val[IPB_SRC_TIMER_THREE];

   // RULE6 gaps stay zero
   always_comb begin
      reg_view = '0;
      for (int i = 0; i < IPB_NUM_SRC; i++) begin
         reg_view[IPB_FIELD_LSB[i] +: IPB_FIELD_W] = prio_val[i];
      end
   end

   // Read path; the data word is the state before any same-edge write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= IPB_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         if (reg_hit(s_axi_araddr)) begin
            s_axi_rdata <= {{(IPB_DATA_W - IPB_REG_W){1'b0}}, reg_view};
            s_axi_rresp <= IPB_RESP_OKAY;
         end else begin
            s_axi_rdata <= '0;
            s_axi_rresp <= IPB_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // RULE3 disabled never requests
   // RULE2 any nonzero level passes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_request <= '0;
      end else begin
         irq_request <= src_request & active_val;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Both halves of a write to the mapped word are held and the response is not yet raised
   sequence s_write_commit;
      wr_commit && reg_hit(aw_addr);
   endsequence

   sequence s_full_strobe;
      w_strb[IPB_SERIAL_RX_LSB / IPB_BYTE_W] &&
      w_strb[IPB_TIMER_THREE_LSB / IPB_BYTE_W];
   endsequence

   sequence s_read_taken;
      s_axi_arvalid && s_axi_arready && reg_hit(s_axi_araddr);
   endsequence

   // Handshake closes and the channel reopens
   sequence s_resp_taken;
      s_axi_bvalid && s_axi_bready;
   endsequence

   sequence s_data_taken;
      s_axi_rvalid && s_axi_rready;
   endsequence

   sequence s_upper_only;
      w_strb[IPB_SERIAL_RX_LSB / IPB_BYTE_W] &&
      !w_strb[IPB_TIMER_THREE_LSB / IPB_BYTE_W];
   endsequence

   a_reset_level_four: // RULE4
   assert property ($rose(aresetn) |->
      serial_rx_priority == IPB_FIELD_RESET &&
      spi_event_priority == IPB_FIELD_RESET &&
      spi_fault_priority == IPB_FIELD_RESET &&
      timer_three_priority == IPB_FIELD_RESET)
      else $error("priority field not at reset level");

   a_unimpl_read_zero: // RULE6
   assert property (s_axi_rvalid |->
      (s_axi_rdata[IPB_REG_W-1:0] & ~IPB_IMPL_MASK) == '0 &&
      s_axi_rdata[IPB_DATA_W-1:IPB_REG_W] == '0)
      else $error("unimplemented bit read as one");

   a_field_read_place: // RULE5
   assert property (s_read_taken |=>
      s_axi_rdata[IPB_SERIAL_RX_LSB +: IPB_FIELD_W] ==
         $past(serial_rx_priority) &&
      s_axi_rdata[IPB_SPI_EVENT_LSB +: IPB_FIELD_W] ==
         $past(spi_event_priority) &&
      s_axi_rdata[IPB_SPI_FAULT_LSB +: IPB_FIELD_W] ==
         $past(spi_fault_priority) &&
      s_axi_rdata[IPB_TIMER_THREE_LSB +: IPB_FIELD_W] ==
         $past(timer_three_priority))
      else $error("field read from wrong position");

   a_write_masked_store: // RULE7
   assert property (s_write_commit ##0 s_full_strobe |=>
      reg_view == ($past(w_data[IPB_REG_W-1:0]) & IPB_IMPL_MASK))
      else $error("write not stored as masked value");

   a_fields_hold_idle: // RULE7
   assert property (!wr_commit |=> $stable(reg_view))
      else $error("field changed without a write");

   a_top_level_store: // RULE1
   assert property (s_write_commit ##0 s_full_strobe ##0
      (w_data[IPB_SERIAL_RX_LSB +: IPB_FIELD_W] == IPB_LEVEL_MAX)
      |=> (serial_rx_priority == IPB_LEVEL_MAX) [*2])
      else $error("level seven not kept");

   generate
      for (gi = 0; gi < IPB_NUM_SRC; gi++) begin : g_check
         a_disabled_silent: // RULE3
         assert property (prio_val[gi] == IPB_FIELD_OFF |=>
            !irq_request[gi])
            else $error("request raised by disabled source");

         a_enabled_passes: // RULE2
         assert property (prio_val[gi] >= IPB_LEVEL_MIN &&
            src_request[gi] |=> irq_request[gi])
            else $error("enabled source request dropped");

         a_field_takes_write: // RULE7
         assert property (s_write_commit ##0
            w_strb[IPB_FIELD_LSB[gi] / IPB_BYTE_W] |=>
            prio_val[gi] == $past(w_data[IPB_FIELD_LSB[gi] +: IPB_FIELD_W]))
            else $error("field did not take written value");

         a_active_tracks: // RULE3
         assert property (active_val[gi] ==
            (prio_val[gi] != IPB_FIELD_OFF))
            else $error("enable flag disagrees with level");
      end
   endgenerate

   a_write_answer: // RULE7
   assert property (wr_commit |=> s_axi_bvalid &&
      s_axi_bresp == (reg_hit($past(aw_addr)) ? IPB_RESP_OKAY :
                      IPB_RESP_SLVERR))
      else $error("write response missing or wrong");

   a_resp_reopens: // RULE7
   assert property (s_resp_taken |=>
      !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write channel not reopened");

   a_read_answer: // RULE7
   assert property (s_read_taken |=> s_axi_rvalid && !s_axi_arready &&
      s_axi_rresp == IPB_RESP_OKAY)
      else $error("read answer late or wrong");

   a_data_reopens: // RULE7
   assert property (s_data_taken |=> !s_axi_rvalid && s_axi_arready)
      else $error("read channel not reopened");

   a_unmapped_no_store: // RULE7
   assert property (wr_commit && !reg_hit(aw_addr) |=> $stable(reg_view))
      else $error("unmapped write reached a field");

   a_unmapped_read_err: // RULE6
   assert property (s_axi_arvalid && s_axi_arready &&
      !reg_hit(s_axi_araddr) |=>
      s_axi_rresp == IPB_RESP_SLVERR && s_axi_rdata == '0)
      else $error("unmapped read not refused");

   // An upper-lane-only strobe leaves the lower byte alone
   a_upper_lane_only: // RULE7
   assert property (s_write_commit ##0 s_upper_only |=>
      reg_view[IPB_BYTE_W-1:0] == $past(reg_view[IPB_BYTE_W-1:0]))
      else $error("lower byte changed by upper-lane write");

   a_reset_irq_quiet: // RULE4
   assert property ($rose(aresetn) |-> irq_request == '0)
      else $error("request raised out of reset");
endmodule : ipb_bank

/* File: logic/ipb_pkg.sv */
/*
 Constants for the interrupt priority bank: register map, field layout,
 reset values and bus response codes.
 Assumes a 32-bit AXI4-Lite register port on a single clock.
*/
// Operation
// RULE1: field 111 means level 7, highest
// RULE2: values from 001 up rank ascending levels
// RULE3: field 000 disables its source entirely
// RULE4: every field resets to 100, level four
// RULE5: fields sit at 14:12, 10:8, 6:4, 2:0
// RULE6: bits 15, 11, 7, 3 read zero
// RULE7: unimplemented bits ignore writes; fields read/write
package ipb_pkg;
   localparam int IPB_ADDR_W = 8;
   localparam int IPB_DATA_W = 32;
   localparam int IPB_STRB_W = IPB_DATA_W / 8;
   localparam int IPB_BYTE_W = 8;
   localparam int IPB_WORD_LSB = 2;
   localparam int IPB_NUM_SRC = 4;
   localparam int IPB_FIELD_W = 3;
   localparam int IPB_REG_W = 16;

   localparam logic [IPB_ADDR_W-1:0] IPB_PRIO_OFFSET = 8'h00;

   // Field positions inside peripheral_priority_two
   localparam int IPB_SERIAL_RX_LSB = 12;
   localparam int IPB_SPI_EVENT_LSB = 8;
   localparam int IPB_SPI_FAULT_LSB = 4;
   localparam int IPB_TIMER_THREE_LSB = 0;

   // Source index i uses IPB_FIELD_LSB[i]
   localparam int IPB_FIELD_LSB [IPB_NUM_SRC] = '{
      IPB_TIMER_THREE_LSB, IPB_SPI_FAULT_LSB,
      IPB_SPI_EVENT_LSB, IPB_SERIAL_RX_LSB};
   localparam int IPB_SRC_TIMER_THREE = 0;
   localparam int IPB_SRC_SPI_FAULT = 1;
   localparam int IPB_SRC_SPI_EVENT = 2;
   localparam int IPB_SRC_SERIAL_RX = 3;

   localparam logic [IPB_FIELD_W-1:0] IPB_FIELD_RESET = 3'h4;
   localparam logic [IPB_FIELD_W-1:0] IPB_FIELD_OFF = 3'h0;
   localparam logic [IPB_FIELD_W-1:0] IPB_LEVEL_MIN = 3'h1;
   localparam logic [IPB_FIELD_W-1:0] IPB_LEVEL_MAX = 3'h7;

   localparam logic [IPB_REG_W-1:0] IPB_IMPL_MASK = 16'h7777;

   localparam logic [1:0] IPB_RESP_OKAY = 2'h0;
   localparam logic [1:0] IPB_RESP_SLVERR = 2'h2;
endpackage : ipb_pkg

/* File: logic/ipb_field_if.sv */
/*
 Carrier between the bank and one priority field store.
 Assumes both ends run on the bank clock.
*/
`timescale 1ns/1ps
interface ipb_field_if;
   import ipb_pkg::*;
   logic wr_en;
   logic [IPB_FIELD_W-1:0] wr_value;
   logic [IPB_FIELD_W-1:0] value;
   logic active;

   modport ctrl (output wr_en, output wr_value,
                 input value, input active);
   modport store (input wr_en, input wr_value,
                  output value, output active);
endinterface : ipb_field_if

/* File: logic/ipb_prio_field.sv */
/*
 One 3-bit priority field with its reset level and an enable flag.
 Assumes write enable and value come from the bank on the same clock.
*/
`timescale 1ns/1ps
module ipb_prio_field (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bank side
   ipb_field_if.store fld
);
   import ipb_pkg::*;

   // RULE4 reset level four
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fld.value <= IPB_FIELD_RESET;
      end else if (fld.wr_en) begin
         // RULE1 all three bits kept
         // RULE7 field fully writable
         fld.value <= fld.wr_value;
      end
   end

   // Kept as a flop so the enable never lags the stored level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fld.active <= (IPB_FIELD_RESET != IPB_FIELD_OFF);
      end else if (fld.wr_en) begin
         // RULE3 zero disables source
         fld.active <= (fld.wr_value != IPB_FIELD_OFF);
      end
   end
endmodule : ipb_prio_field

/* File: test/ipb_bank_bench.sv */
/*
 Self-checking bench for ipb_bank: register traffic over AXI4-Lite,
 field outputs and request gating.
 Assumes the bank's reset values and handshake timing as handed over.
*/
`timescale 1ns/1ps
module ipb_bank_bench;
   import ipb_pkg::*;
   logic aclk, aresetn;
   logic [7:0] awaddr, araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, src, irq;
   logic [1:0] bresp, rresp;
   logic [2:0] ser, evt, flt, tmr;
   logic [31:0] fld_word;
   int failures, tests_run;
   logic [31:0] wr_val [5] = '{32'hFFFF_FFFF, 32'h0000_0123,
      32'h0000_7000, 32'h0000_00FF, 32'h0000_8888};
   logic [3:0] wr_strb [5] = '{4'hF, 4'hF, 4'h2, 4'h1, 4'hF};
   logic [15:0] exp_reg [5] = '{16'h7777, 16'h0123, 16'h7023,
      16'h7077, 16'h0000};
   logic [3:0] src_pat [5] = '{4'hF, 4'hF, 4'h5, 4'hA, 4'hF};
   logic [3:0] exp_irq [5] = '{4'hF, 4'h7, 4'h1, 4'hA, 4'h0};

   assign fld_word = {16'h0, 1'b0, ser, 1'b0, evt, 1'b0, flt, 1'b0, tmr};

   ipb_bank #(.ADDR_W(IPB_ADDR_W)) DUT (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .src_request(src), .irq_request(irq),
      .serial_rx_priority(ser), .spi_event_priority(evt),
      .spi_fault_priority(flt), .timer_three_priority(tmr)
   );

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic check_word(input logic [31:0] got,
         input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_word

   // Called just after a rising edge; returns just after one
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s, input logic [1:0] r);
      logic aw_pend, w_pend, aw_go, w_go;
      aw_pend = 1'b1;
      w_pend = 1'b1;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // Readies only move on rising edges, so the falling edge is safe
      while (aw_pend || w_pend) begin
         @(negedge aclk);
         aw_go = aw_pend && awready === 1'b1;
         w_go = w_pend && wready === 1'b1;
         @(posedge aclk);
         if (aw_go) awvalid <= 1'b0;
         if (w_go) wvalid <= 1'b0;
         aw_pend = aw_pend && !aw_go;
         w_pend = w_pend && !w_go;
      end
      do @(negedge aclk); while (bvalid !== 1'b1);
      check_word({30'h0, bresp}, {30'h0, r});
      @(posedge aclk);
      bready <= 1'b0;
      @(posedge aclk);
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
         output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_read

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      aresetn = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      wdata = 32'h0;
      wstrb = 4'h0;
      src = 4'hF;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      axi_read(IPB_PRIO_OFFSET, d, r);
      check_word(d, 32'h0000_4444);
      check_word({30'h0, r}, {30'h0, IPB_RESP_OKAY});
      check_word(fld_word, 32'h0000_4444);
      check_word({28'h0, irq}, 32'h0000_000F);
      // Full, upper-lane and lower-lane writes, each with gating
      for (int i = 0; i < 5; i++) begin
         axi_write(IPB_PRIO_OFFSET, wr_val[i], wr_strb[i], IPB_RESP_OKAY);
         src <= src_pat[i];
         @(posedge aclk);
         @(negedge aclk);
         check_word({28'h0, irq}, {28'h0, exp_irq[i]});
         @(posedge aclk);
         axi_read(IPB_PRIO_OFFSET, d, r);
         check_word(d, {16'h0, exp_reg[i]});
         check_word(fld_word, {16'h0, exp_reg[i]});
      end
      // Unmapped word must not reach the fields
      axi_write(8'h04, 32'h0000_7777, 4'hF, IPB_RESP_SLVERR);
      axi_read(8'h04, d, r);
      check_word(d, 32'h0);
      check_word({30'h0, r}, {30'h0, IPB_RESP_SLVERR});
      axi_read(IPB_PRIO_OFFSET, d, r);
      check_word(d, 32'h0);
      test_done;
   end

   // Whole run takes under a hundred cycles
   initial begin
      repeat (3000) @(posedge aclk);
      failures++;
      test_done;
   end
endmodule : ipb_bank_bench
